// File: wwd_pkg.sv
// Package for the windowed watchdog counter: register map, field layout, timing.
// Assumes a single 250 MHz clock domain shared by the whole block.
package wwd_pkg;

  // Register map.
  localparam logic [7:0] WWD_CTRL_ADDR = 8'h2a;
  localparam logic [7:0] WWD_CTRL_RESET = 8'h7f;
  localparam int WWD_ACT_BIT = 7;
  localparam int WWD_TOP_BIT = 6;

  // Counter thresholds.
  localparam logic [6:0] WWD_CNT_FIRE_FROM = 7'h40;

  // Decrement period in oscillator cycles.
  localparam int WWD_TICK_CYCLES = 16384;

  // Wake-up start-up delays in processor clocks.
  localparam int WWD_WAKE_SHORT = 256;
  localparam int WWD_WAKE_LONG = 4096;

  // Reset pulse width: 30 us at a 4 ns clock period.
  localparam int WWD_RST_PULSE_NS = 30000;
  localparam int WWD_CLK_PERIOD_NS = 4;
  localparam int WWD_RST_PULSE_CYCLES = WWD_RST_PULSE_NS / WWD_CLK_PERIOD_NS;

  // Timeout-formula constants.
  localparam int WWD_STEP_BASE = 192;
  localparam int WWD_STEP_MULT = 64;

  // Halt behaviour states.
  typedef enum logic [1:0] {
    WWD_RUN,
    WWD_HALT_ONE,
    WWD_FROZEN,
    WWD_WAKE_WAIT
  } wwd_state_e;

endpackage

// File: wwd_watchdog.sv
// Windowed watchdog counter: control register, free-running down-counter,
// reset generation and low-power (halt / active-halt) handling.
// Assumes the CPU core supplies halt and wake strobes synchronous to mclk and
// that option inputs are static after reset.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module wwd_watchdog
  import wwd_pkg::*;
#(
  parameter int TICK_CYCLES = WWD_TICK_CYCLES,
  parameter int WAKE_DELAY = WWD_WAKE_LONG,
  parameter int RST_PULSE = WWD_RST_PULSE_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Static options and clock controller status.
  input wire logic halt_reset_option,
  input wire logic hw_watchdog_option,
  input wire logic timebase_irq_enable,
  // Low-power events from the core.
  input wire logic halt_exec,
  input wire logic ext_irq_wake,
  input wire logic osc_irq_wake,
  input wire logic came_from_active_halt,
  // Reset pin output, active low.
  output logic reset_pin_n
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int WW = $clog2(WAKE_DELAY + 1);
  localparam int PW = $clog2(RST_PULSE + 1);

  // Decoded register access.
  function automatic logic hit(input logic [7:0] a);
    hit = (a == WWD_CTRL_ADDR);
  endfunction

  logic activation_bit;
  logic [6:0] count;
  logic [TW-1:0] prescale;
  logic [WW-1:0] wake_cnt;
  logic [PW-1:0] pulse_cnt;
  wwd_state_e state;
  logic boot_delay;
  logic opt_hw;
  logic opt_halt_rst;

  logic next_activation_bit;
  logic [6:0] next_count;
  logic [TW-1:0] next_prescale;
  logic [WW-1:0] next_wake_cnt;
  logic [PW-1:0] next_pulse_cnt;
  wwd_state_e next_state;
  logic next_boot_delay;
  logic next_opt_hw;
  logic next_opt_halt_rst;
  logic [7:0] next_rdata;

  logic tick;
  logic active;
  logic counting;
  logic fire;
  logic halt_fire;
  logic write_hit;

  // Options are latched once after reset so later pin glitches cannot matter.
  assign active = activation_bit | opt_hw;
  assign write_hit = wr & hit(addr);
  // Counting stops in frozen halt states and during wake-up delays.
  assign counting = (state == WWD_RUN) | (state == WWD_HALT_ONE);
  assign tick = counting & (prescale == TW'(TICK_CYCLES - 1));
  // Step from 40h to 3Fh when active; forced reset on write with top bit low.
  // The write that sets bit 7 counts as active itself, so software can fire from cold.
  assign fire = (active & tick & ~write_hit & (count == WWD_CNT_FIRE_FROM))
    | (write_hit & (active | wdata[WWD_ACT_BIT]) & ~wdata[WWD_TOP_BIT]);
  assign halt_fire = halt_exec & (state == WWD_RUN) & ~timebase_irq_enable
    & opt_halt_rst;

  // Next-state logic for counter, control bits, halt handling and pulse.
  always_comb begin
    next_activation_bit = activation_bit;
    next_count = count;
    next_prescale = prescale;
    next_wake_cnt = wake_cnt;
    next_pulse_cnt = pulse_cnt;
    next_state = state;
    next_boot_delay = 1'b0;
    next_opt_hw = opt_hw;
    next_opt_halt_rst = opt_halt_rst;
    next_rdata = 8'h00;
    if (boot_delay) begin
      next_opt_hw = hw_watchdog_option;
      next_opt_halt_rst = halt_reset_option;
    end
    if (rd && hit(addr)) begin
      next_rdata = {activation_bit, count};
    end
    // Prescaler runs only in the counting states; runs regardless of activation.
    if (counting) begin
      next_prescale = tick ? '0 : prescale + TW'(1);
    end
    if (tick) begin
      next_count = count - 7'h01;
    end
    if (write_hit) begin
      next_count = wdata[6:0];
      // Only software can set; clearing happens only through reset.
      next_activation_bit = activation_bit | wdata[WWD_ACT_BIT];
    end
    case (state)
      WWD_RUN: begin
        if (halt_exec && !timebase_irq_enable && !opt_halt_rst) begin
          next_state = WWD_HALT_ONE;
        end else if (halt_exec && timebase_irq_enable) begin
          next_state = WWD_FROZEN;
        end
      end
      WWD_HALT_ONE: begin
        // One more decrement, then freeze.
        if (tick) begin
          next_state = WWD_FROZEN;
        end
      end
      WWD_FROZEN: begin
        if (timebase_irq_enable && (osc_irq_wake || ext_irq_wake)) begin
          next_state = WWD_RUN;
        end else if (ext_irq_wake) begin
          next_state = WWD_WAKE_WAIT;
          next_wake_cnt = '0;
        end
      end
      WWD_WAKE_WAIT: begin
        next_wake_cnt = wake_cnt + WW'(1);
        if (wake_cnt == WW'(WAKE_DELAY - 1)) begin
          next_state = WWD_RUN;
        end
      end
      default: begin
        next_state = WWD_RUN;
      end
    endcase
    // First cycle after reset: a reset that ended active-halt waits out the delay.
    if (boot_delay) begin
      next_wake_cnt = '0;
      if (came_from_active_halt) begin
        next_state = WWD_WAKE_WAIT;
      end
    end
    if (pulse_cnt != '0) begin
      next_pulse_cnt = pulse_cnt - PW'(1);
    end
    // Only normal running may fire; plain halt entry, frozen and wake-up states never do.
    if ((fire && state == WWD_RUN) || halt_fire) begin
      next_pulse_cnt = PW'(RST_PULSE);
    end
  end

  // Registers only; every decision is taken in the process above.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      activation_bit <= 1'b0;
      count <= WWD_CTRL_RESET[6:0];
      prescale <= '0;
      wake_cnt <= '0;
      pulse_cnt <= '0;
      state <= WWD_RUN;
      boot_delay <= 1'b1;
      opt_hw <= 1'b0;
      opt_halt_rst <= 1'b0;
      rdata <= 8'h00;
    end else begin
      activation_bit <= next_activation_bit;
      count <= next_count;
      prescale <= next_prescale;
      wake_cnt <= next_wake_cnt;
      pulse_cnt <= next_pulse_cnt;
      state <= next_state;
      boot_delay <= next_boot_delay;
      opt_hw <= next_opt_hw;
      opt_halt_rst <= next_opt_halt_rst;
      rdata <= next_rdata;
    end
  end

  // Reset pin is low while the pulse counter runs.
  assign reset_pin_n = (pulse_cnt == '0);

  // Reset pulse follows a firing event by one cycle.
  property p_fire_pulse;
    @(posedge mclk) disable iff (!resetn)
      (fire && state == WWD_RUN) |=> !reset_pin_n;
  endproperty
  a_fire_pulse: assert property (p_fire_pulse) else $error("fire gave no reset pulse");

  property p_act_sticky;
    @(posedge mclk) disable iff (!resetn)
      activation_bit |=> activation_bit;
  endproperty
  a_act_sticky: assert property (p_act_sticky) else $error("activation bit cleared");

  property p_tick_dec;
    @(posedge mclk) disable iff (!resetn)
      (tick && !write_hit) |=> count == $past(count) - 7'h01;
  endproperty
  a_tick_dec: assert property (p_tick_dec) else $error("count did not step");

  property p_frozen_hold;
    @(posedge mclk) disable iff (!resetn)
      (state == WWD_FROZEN && !write_hit) |=> count == $past(count);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("frozen count moved");

  property p_halt_reset;
    @(posedge mclk) disable iff (!resetn)
      halt_fire |=> !reset_pin_n;
  endproperty
  a_halt_reset: assert property (p_halt_reset) else $error("halt reset missing");

  property p_active_halt;
    @(posedge mclk) disable iff (!resetn)
      (state == WWD_RUN && halt_exec && timebase_irq_enable) |=> state == WWD_FROZEN;
  endproperty
  a_active_halt: assert property (p_active_halt) else $error("no active-halt freeze");

  property p_no_reset_frozen;
    @(posedge mclk) disable iff (!resetn)
      (state == WWD_FROZEN && pulse_cnt == '0 && !halt_exec) |=> reset_pin_n;
  endproperty
  a_no_reset_frozen: assert property (p_no_reset_frozen) else $error("reset while frozen");

  property p_wake_wait;
    @(posedge mclk) disable iff (!resetn)
      (state == WWD_WAKE_WAIT && wake_cnt != WW'(WAKE_DELAY - 1)) |=> state == WWD_WAKE_WAIT;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake delay cut short");

  property p_pulse_len;
    @(posedge mclk) disable iff (!resetn)
      $fell(reset_pin_n) |-> !reset_pin_n [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");

  // Checked without a disable so that the reset values themselves are covered.
  property p_reset_value;
    @(posedge mclk)
      !resetn |=> (activation_bit == 1'b0 && count == WWD_CTRL_RESET[6:0] && reset_pin_n);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset state wrong");

  property p_forced_fire;
    @(posedge mclk) disable iff (!resetn)
      (write_hit && wdata[WWD_ACT_BIT] && !wdata[WWD_TOP_BIT] && state == WWD_RUN)
        |=> !reset_pin_n;
  endproperty
  a_forced_fire: assert property (p_forced_fire) else $error("no forced reset");

  property p_quiet_idle;
    @(posedge mclk) disable iff (!resetn)
      (!active && !write_hit && !halt_fire && pulse_cnt == '0) |=> reset_pin_n;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("fired while idle");

  property p_write_load;
    @(posedge mclk) disable iff (!resetn)
      write_hit |=> {1'b0, count} == ($past(wdata) & 8'h7f);
  endproperty
  a_write_load: assert property (p_write_load) else $error("write not loaded");

  property p_read_idle;
    @(posedge mclk) disable iff (!resetn)
      !(rd && hit(addr)) |=> rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("stray read data");

  property p_plain_halt;
    @(posedge mclk) disable iff (!resetn)
      (state == WWD_RUN && halt_exec && !timebase_irq_enable && !opt_halt_rst)
        |=> state == WWD_HALT_ONE;
  endproperty
  a_plain_halt: assert property (p_plain_halt) else $error("no plain halt");

  property p_wake_now;
    @(posedge mclk) disable iff (!resetn)
      (state == WWD_FROZEN && timebase_irq_enable && (osc_irq_wake || ext_irq_wake))
        |=> state == WWD_RUN;
  endproperty
  a_wake_now: assert property (p_wake_now) else $error("late active-halt wake");

  property p_boot_wait;
    @(posedge mclk) disable iff (!resetn)
      (boot_delay && came_from_active_halt) |=> state == WWD_WAKE_WAIT;
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("no boot wake wait");

endmodule

// File: windowed_watchdog_counter_tb.sv
// Self-checking testbench for the windowed watchdog counter.
// Assumes wwd_pkg and wwd_watchdog are compiled first; the bench drives every port.
`timescale 1ns/1ps
module windowed_watchdog_counter_tb;
  import wwd_pkg::*;
  // Shortened counts keep the run brief; every expectation uses these values.
  localparam int TICK = 16;
  localparam int WAKE = 8;
  localparam int PULSE = 8;
  logic mclk, resetn, wr, rd, hro, hwo, tbie, halt_exec, ext_wake, osc_wake, cfah;
  logic [7:0] addr, wdata, rdata, v0, v1;
  logic reset_pin_n;
  int n_errors, checked, n, seed, cyc;

  wwd_watchdog #(.TICK_CYCLES(TICK), .WAKE_DELAY(WAKE), .RST_PULSE(PULSE)) dut_u (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .halt_reset_option(hro), .hw_watchdog_option(hwo),
    .timebase_irq_enable(tbie), .halt_exec(halt_exec), .ext_irq_wake(ext_wake),
    .osc_irq_wake(osc_wake), .came_from_active_halt(cfah), .reset_pin_n(reset_pin_n));

  // Free-running 250 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Edges since reset release; while running, the prescaler phase is this modulo TICK.
  always @(posedge mclk) cyc <= resetn ? cyc + 1 : 0;

  // Control value after k decrements of the count field; bit 7 never moves.
  function automatic logic [7:0] after_ticks(input logic [7:0] v, input int k);
    after_ticks = {v[7], v[6:0] - 7'(k)};
  endfunction

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Options are held through reset because the block samples them at release.
  task automatic do_reset(input logic h_opt, input logic w_opt, input int len);
    @(posedge mclk);
    resetn <= 1'b0;
    hro <= h_opt;
    hwo <= w_opt;
    repeat (len) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [7:0] d);
    @(posedge mclk);
    addr <= WWD_CTRL_ADDR;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // One-cycle pulse on halt (0), external wake (1) or oscillator wake (2).
  task automatic strobe(input int k);
    @(posedge mclk);
    halt_exec <= (k == 0);
    ext_wake <= (k == 1);
    osc_wake <= (k == 2);
    @(posedge mclk);
    {halt_exec, ext_wake, osc_wake} <= 3'b000;
  endtask

  // Bounded wait for the reset pin; a required fire that never comes ends the run.
  task automatic wait_fire(input int lim, input bit must);
    n = 0;
    #1;
    while (reset_pin_n !== 1'b0 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    if (must) begin
      check("fire", 8'(reset_pin_n), 8'h00);
      if (n >= lim) complete_run();
    end
  endtask

  // Waits until a decrement has just happened, so later reads know the exact count.
  task automatic align();
    n = 0;
    while (cyc % TICK != 0 && n < TICK) begin
      @(posedge mclk);
      #1 n++;
    end
    check("align", 8'(cyc % TICK), 8'h00);
  endtask

  task automatic frozen_then_wake(input int k);
    rd_reg(WWD_CTRL_ADDR, v0);
    repeat (3 * TICK) @(posedge mclk);
    rd_reg(WWD_CTRL_ADDR, v1);
    check("frozen", v1, v0);
    check("no fire", 8'(reset_pin_n), 8'h01);
    strobe(k);
    repeat (WAKE + TICK + 2) @(posedge mclk);
    rd_reg(WWD_CTRL_ADDR, v1);
    check("resumed", 8'(v1 < v0), 8'h01);
  endtask

  // Main sequence: directed corners with random reload values among them.
  initial begin
    {wr, rd, hro, hwo, tbie, halt_exec, ext_wake, osc_wake, cfah} = '0;
    {addr, wdata} = '0;
    resetn = 1'b0;
    n_errors = 0;
    checked = 0;
    seed = 32'h6010;
    do_reset(1'b0, 1'b0, 12);
    rd_reg(WWD_CTRL_ADDR, v0);
    check("reset value", v0, WWD_CTRL_RESET);
    rd_reg(WWD_CTRL_ADDR + 8'h01, v0);
    check("unmapped", v0, 8'h00);
    // Disabled reloads keep counting one step per tick period; the write lands
    // two edges after a decrement, so the first read is exact and the second
    // falls just after the following decrement.
    for (int i = 0; i < 6; i++) begin
      v1 = {2'b01, 6'($random(seed))};
      align();
      wr_reg(v1);
      rd_reg(WWD_CTRL_ADDR, v0);
      check("reload", v0, after_ticks(v1, 0));
      repeat (TICK - 2) @(posedge mclk);
      rd_reg(WWD_CTRL_ADDR, v0);
      check("tick", v0, after_ticks(v1, 1));
    end
    wr_reg(8'h41);
    wait_fire(3 * TICK, 1'b0);
    check("disabled quiet", 8'(n), 8'(3 * TICK));
    // Active roll-over from 40h fires after two ticks, then a fixed pulse.
    wr_reg(8'hc1);
    wait_fire(3 * TICK, 1'b1);
    check("fire time", 8'(n >= TICK && n <= 2 * TICK + 2), 8'h01);
    n = 0;
    while (reset_pin_n === 1'b0 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    check("pulse width", 8'(n), 8'(PULSE));
    wr_reg(8'h7f);
    rd_reg(WWD_CTRL_ADDR, v0);
    check("act sticks", v0 & 8'h80, 8'h80);
    do_reset(1'b0, 1'b0, 2);
    rd_reg(WWD_CTRL_ADDR, v0);
    check("act cleared", v0, 8'h7f);
    // Software-forced resets with random low counts, written from the disabled state.
    for (int i = 0; i < 3; i++) begin
      wr_reg({2'b10, 6'($random(seed))});
      wait_fire(3, 1'b1);
      do_reset(1'b0, 1'b0, 2);
    end
    do_reset(1'b0, 1'b1, 2);
    wr_reg(8'h41);
    wait_fire(3 * TICK, 1'b1);
    do_reset(1'b1, 1'b0, 2);
    strobe(0);
    wait_fire(4, 1'b1);
    // Plain halt while active, then active-halt; reload first to avoid a wake-up fire.
    do_reset(1'b0, 1'b0, 2);
    wr_reg(8'hff);
    strobe(0);
    repeat (2 * TICK) @(posedge mclk);
    frozen_then_wake(1);
    wr_reg(8'hff);
    tbie <= 1'b1;
    strobe(0);
    frozen_then_wake(2);
    // Reset out of active-halt: the count holds through the wake delay, then resumes.
    // Without the delay the first decrement would land before the first read.
    cfah <= 1'b1;
    do_reset(1'b0, 1'b0, 2);
    cfah <= 1'b0;
    repeat (TICK + 2) @(posedge mclk);
    rd_reg(WWD_CTRL_ADDR, v0);
    check("boot wait", v0, WWD_CTRL_RESET);
    repeat (2) @(posedge mclk);
    rd_reg(WWD_CTRL_ADDR, v0);
    check("boot resume", v0, after_ticks(WWD_CTRL_RESET, 1));
    complete_run();
  end
endmodule
